// *** rtl/pms_defines.vh ***
`ifndef PMS_DEFINES_VH
`define PMS_DEFINES_VH

// ==================================================================
// Requested power modes.
`define PMS_MODE_RUN 3'h0
`define PMS_MODE_HSRUN 3'h1
`define PMS_MODE_VLP_RUN 3'h2

// ==================================================================
// Sequencer states.
`define PMS_ST_RUN 3'h0
`define PMS_ST_SLEEP 3'h1
`define PMS_ST_STOP_ACK 3'h2
`define PMS_ST_DEEP 3'h3

// ==================================================================
// Flash access speed codes and oscillator source codes.
`define PMS_FLASH_FULL 1'h0
`define PMS_FLASH_1MHZ 1'h1
`define PMS_SRC_NORMAL 1'h0
`define PMS_SRC_IRC_4MHZ 1'h1

// ==================================================================
// Levels of the enable and request outputs.
`define PMS_ON 1'h1
`define PMS_OFF 1'h0

// ==================================================================
// Stop acknowledge width and synchroniser reset value.
`define PMS_NUM_ACK 4
`define PMS_NUM_WAKE 4
`define PMS_ACK_ALL 4'hf
`define PMS_ZERO_ACK 4'h0

`endif

// *** rtl/pms_sync.v ***
`timescale 1ns/1ns

// ==================================================================
// Two flop synchroniser for a bundle of asynchronous levels.
module pms_sync #(
  parameter W = 1
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta_q;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_q <= {W{1'h0}};
      sync_o <= {W{1'h0}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // pms_sync

// *** rtl/pms_power_mode_sequencer.v ***
`timescale 1ns/1ns
`include "pms_defines.vh"

// Function
// - Sleep or deep sleep is entered only on a wait-for-interrupt instruction or on a return from the last handler with sleep-after-handler set.
// - Sleep gates the core clock; deep sleep gates the core and interrupt controller clocks.
// - In sleep the interrupt controller stays live; any interrupt or reset wakes.
// - Deep sleep wakes only through the async wake controller from enabled sources.
// - Sleep-after-handler enters low power when the last handler returns.
// - Normal run gives full speed with full regulation.
// - High-speed run allows a faster clock with full regulation.
// - Normal wait sleeps the core; peripherals clocked; interrupts stay live.
// - Normal stop keeps registers and voltage detect; stops controller and peripherals.
// - Bus and master clocks gate only after all stop acknowledges are valid.
// - Very-low-power run uses 1 MHz flash, voltage detect off, 4 MHz source.
// - Very-low-power wait equals that run but core sleeps; controller clock on.
// - Very-low-power stop turns controller clock off; wakes via async controller.
module pms_power_mode_sequencer (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [2:0] run_mode_i,
  input wire deep_sleep_sel_i,
  input wire sleep_after_handler_bit_i,
  input wire wait_for_interrupt_instr_i,
  input wire exception_return_i,
  input wire handlers_pending_i,
  input wire irq_pending_i,
  input wire [3:0] wake_src_i,
  input wire [3:0] wake_enable_i,
  input wire [3:0] stop_ack_i,
  output reg core_clk_en_o,
  output reg irq_ctrl_clk_en_o,
  output reg sys_clk_en_o,
  output reg bus_clk_en_o,
  output reg periph_clk_en_o,
  output reg stop_req_o,
  output reg async_wake_sel_o,
  output reg low_voltage_detect_en_o,
  output reg full_regulation_o,
  output reg high_speed_en_o,
  output reg flash_slow_o,
  output reg clk_src_irc_o,
  output reg [2:0] state_o
);

  // ==================================================================
  // Asynchronous inputs pass two flops before any logic reads them.
  // Reset clears both stages, so no stale acknowledge is seen after reset.
  wire [3:0] wake_src_s;
  wire [3:0] stop_ack_s;

  pms_sync #(
    .W(`PMS_NUM_WAKE + `PMS_NUM_ACK)
  ) pms_sync_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({wake_src_i, stop_ack_i}),
    .sync_o({wake_src_s, stop_ack_s})
  );

  // ==================================================================
  // Wake qualification, one enable per source.
  wire [3:0] wake_hit;
  wire async_wake;

  genvar g;
  generate
    for (g = 0; g < `PMS_NUM_WAKE; g = g + 1) begin : g_wake
      assign wake_hit[g] = wake_src_s[g] & wake_enable_i[g];
    end
  endgenerate

  // Only sources selected by the enable mask can end a stop.
  assign async_wake = |wake_hit;

  // ==================================================================
  // Entry trigger.
  wire handler_exit;
  wire entry;

  // Returning from the last handler with sleep-after-handler set acts as a new instruction.
  assign handler_exit = sleep_after_handler_bit_i && exception_return_i &&
    !handlers_pending_i;
  assign entry = wait_for_interrupt_instr_i || handler_exit;

  // ==================================================================
  // State machine.
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] mode_q;
  reg [2:0] mode_d;

  always @* begin
    mode_d = mode_q;
    // The run flavour is only taken while running, so it is held through wait and stop.
    if (state_q == `PMS_ST_RUN) begin
      mode_d = run_mode_i;
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      `PMS_ST_RUN: begin
        if (entry) begin
          if (deep_sleep_sel_i) begin
            state_d = `PMS_ST_STOP_ACK;
          end else begin
            state_d = `PMS_ST_SLEEP;
          end
        end
      end
      `PMS_ST_SLEEP: begin
        // Any pending interrupt ends sleep, since the controller clock still runs.
        if (irq_pending_i) begin
          state_d = `PMS_ST_RUN;
        end
      end
      `PMS_ST_STOP_ACK: begin
        // A wake seen while acknowledges are still pending aborts the stop entry.
        if (async_wake) begin
          state_d = `PMS_ST_RUN;
        end else if (stop_ack_s == `PMS_ACK_ALL) begin
          state_d = `PMS_ST_DEEP;
        end
      end
      `PMS_ST_DEEP: begin
        // Interrupts are not seen here; only the async wake path ends a stop.
        if (async_wake) begin
          state_d = `PMS_ST_RUN;
        end
      end
      default: begin
        state_d = `PMS_ST_RUN;
      end
    endcase
  end

  // ==================================================================
  // State registers.
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= `PMS_ST_RUN;
      mode_q <= `PMS_MODE_RUN;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
    end
  end

  // ==================================================================
  // Output decode from the next state, so every output leaves a flop.
  // The outputs therefore change at the same edge as the state.
  wire vlp_n;
  wire asleep_n;
  wire stopping_n;
  wire deep_n;
  reg core_clk_en_d;
  reg irq_ctrl_clk_en_d;
  reg sys_clk_en_d;
  reg bus_clk_en_d;
  reg periph_clk_en_d;
  reg stop_req_d;
  reg async_wake_sel_d;
  reg low_voltage_detect_en_d;
  reg full_regulation_d;
  reg high_speed_en_d;
  reg flash_slow_d;
  reg clk_src_irc_d;

  assign vlp_n = (mode_d == `PMS_MODE_VLP_RUN);
  assign asleep_n = (state_d != `PMS_ST_RUN);
  assign stopping_n = (state_d == `PMS_ST_STOP_ACK);
  assign deep_n = (state_d == `PMS_ST_DEEP);

  always @* begin
    core_clk_en_d = !asleep_n;
    // The controller clock stays on in plain sleep so interrupts still wake the core.
    irq_ctrl_clk_en_d = !stopping_n && !deep_n;
    // System and bus clocks wait for every stop acknowledge before gating.
    sys_clk_en_d = !deep_n;
    bus_clk_en_d = !deep_n;
    periph_clk_en_d = !deep_n;
    stop_req_d = stopping_n || deep_n;
    async_wake_sel_d = stopping_n || deep_n;
    // The very-low-power flavour is kept through wait and stop.
    low_voltage_detect_en_d = !vlp_n;
    full_regulation_d = !vlp_n;
    high_speed_en_d = (mode_d == `PMS_MODE_HSRUN) && !asleep_n;
    flash_slow_d = vlp_n ? `PMS_FLASH_1MHZ : `PMS_FLASH_FULL;
    clk_src_irc_d = vlp_n ? `PMS_SRC_IRC_4MHZ : `PMS_SRC_NORMAL;
  end

  // Reset leaves normal run with every clock running.
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      core_clk_en_o <= `PMS_ON;
      irq_ctrl_clk_en_o <= `PMS_ON;
      sys_clk_en_o <= `PMS_ON;
      bus_clk_en_o <= `PMS_ON;
      periph_clk_en_o <= `PMS_ON;
      stop_req_o <= `PMS_OFF;
      async_wake_sel_o <= `PMS_OFF;
      low_voltage_detect_en_o <= `PMS_ON;
      full_regulation_o <= `PMS_ON;
      high_speed_en_o <= `PMS_OFF;
      flash_slow_o <= `PMS_FLASH_FULL;
      clk_src_irc_o <= `PMS_SRC_NORMAL;
      state_o <= `PMS_ST_RUN;
    end else begin
      core_clk_en_o <= core_clk_en_d;
      irq_ctrl_clk_en_o <= irq_ctrl_clk_en_d;
      sys_clk_en_o <= sys_clk_en_d;
      bus_clk_en_o <= bus_clk_en_d;
      periph_clk_en_o <= periph_clk_en_d;
      stop_req_o <= stop_req_d;
      async_wake_sel_o <= async_wake_sel_d;
      low_voltage_detect_en_o <= low_voltage_detect_en_d;
      full_regulation_o <= full_regulation_d;
      high_speed_en_o <= high_speed_en_d;
      flash_slow_o <= flash_slow_d;
      clk_src_irc_o <= clk_src_irc_d;
      state_o <= state_d;
    end
  end
endmodule // pms_power_mode_sequencer

// *** testbench/pms_periph_model.sv ***
`timescale 1ns/1ns
// ========
// Peripherals that answer a stop request, all at once or one by one.
module pms_periph_model (
  input wire clk_i,
  input wire slow_i,
  input wire stop_req_i,
  output wire [3:0] stop_ack_o
);
  logic [7:0] sh_q = 8'h00;
  always @(posedge clk_i) sh_q <= {sh_q[6:0], stop_req_i};
  assign stop_ack_o = slow_i ? {sh_q[7], sh_q[5], sh_q[3], sh_q[1]} : {4{sh_q[0]}};
endmodule // pms_periph_model

// *** testbench/pms_sva.sv ***
`timescale 1ns/1ns
module pms_sva (
  input wire ref_clk_i,
  input wire rst_i,
  input wire deep_sleep_sel_i,
  input wire wait_for_interrupt_instr_i,
  input wire irq_pending_i,
  input wire core_clk_en_o,
  input wire irq_ctrl_clk_en_o,
  input wire sys_clk_en_o,
  input wire bus_clk_en_o,
  input wire periph_clk_en_o,
  input wire stop_req_o,
  input wire async_wake_sel_o,
  input wire low_voltage_detect_en_o,
  input wire flash_slow_o,
  input wire clk_src_irc_o,
  input wire [2:0] state_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  core_gate_a: assert property (state_o != 3'h0 |-> !core_clk_en_o) else $error("core clk");
  sleep_live_a: assert property (state_o == 3'h1 |-> irq_ctrl_clk_en_o && periph_clk_en_o) else $error("sleep clk");
  sleep_wake_a: assert property (state_o == 3'h1 && irq_pending_i |=> state_o == 3'h0 && core_clk_en_o) else $error("wake");
  wfi_entry_a: assert property (state_o == 3'h0 && wait_for_interrupt_instr_i |=> state_o == ($past(deep_sleep_sel_i) ? 3'h2 : 3'h1)) else $error("entry");
  ack_hold_a: assert property (state_o == 3'h2 |-> bus_clk_en_o && sys_clk_en_o && stop_req_o && async_wake_sel_o) else $error("ack wait");
  deep_gate_a: assert property (state_o == 3'h3 |-> !(sys_clk_en_o || bus_clk_en_o || periph_clk_en_o || irq_ctrl_clk_en_o) && async_wake_sel_o) else $error("deep");
  vlp_flags_a: assert property (flash_slow_o |-> clk_src_irc_o && !low_voltage_detect_en_o) else $error("vlp");
  reset_run_a: assert property (disable iff (1'h0) rst_i |=> state_o == 3'h0 && core_clk_en_o && bus_clk_en_o && !stop_req_o) else $error("reset");
  cover property (state_o == 3'h3);
  cover property (state_o == 3'h1 && irq_pending_i);
  cover property (flash_slow_o && state_o == 3'h1);
endmodule // pms_sva
bind pms_power_mode_sequencer pms_sva pms_sva_i (.*);

// *** testbench/pms_power_mode_sequencer_test.sv ***
`timescale 1ns/1ns
module pms_power_mode_sequencer_test;
  logic ref_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic dsel = 1'h0, soe = 1'h0, sleep_ins = 1'h0, eret = 1'h0, hp = 1'h0, irq = 1'h0;
  logic slow = 1'h0;
  logic [2:0] mode = 3'h0;
  logic [3:0] wsrc = 4'h0, wen = 4'h0;
  wire [3:0] ack;
  wire [2:0] st;
  wire [4:0] ce;
  wire sreq, aws, volt_det, freg, hs, fs, irc;
  int err_total = 0, tests_run = 0, lf = 72287, n;
  initial forever #5 ref_clk_i = ~ref_clk_i;
  pms_power_mode_sequencer pms_power_mode_sequencer_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .run_mode_i(mode), .deep_sleep_sel_i(dsel), .sleep_after_handler_bit_i(soe),
    .wait_for_interrupt_instr_i(sleep_ins), .exception_return_i(eret), .handlers_pending_i(hp),
    .irq_pending_i(irq), .wake_src_i(wsrc), .wake_enable_i(wen), .stop_ack_i(ack),
    .core_clk_en_o(ce[4]), .irq_ctrl_clk_en_o(ce[3]), .sys_clk_en_o(ce[2]),
    .bus_clk_en_o(ce[1]), .periph_clk_en_o(ce[0]), .stop_req_o(sreq), .async_wake_sel_o(aws),
    .low_voltage_detect_en_o(volt_det), .full_regulation_o(freg), .high_speed_en_o(hs),
    .flash_slow_o(fs), .clk_src_irc_o(irc), .state_o(st));
  pms_periph_model pms_periph_model_i (.clk_i(ref_clk_i), .slow_i(slow), .stop_req_i(sreq),
    .stop_ack_o(ack));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Expected clock enables {core, irq, sys, bus, periph} for a sequencer state.
  function automatic logic [4:0] cex(input int s);
    return s == 0 ? 5'h1f : s == 1 ? 5'h0f : s == 2 ? 5'h07 : 5'h00;
  endfunction
  function automatic int lfsr_next(input int v);
    return ((v << 1) | (v[16] ^ v[13])) & 32'h0001_ffff;
  endfunction
  // Reference state from the rules; acknowledge and wake source inputs reach it two edges late through queues.
  int mdl_st = 0;
  logic [3:0] ack_q[$], wake_q[$];
  logic [3:0] ack_old, wake_old;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_q = '{4'h0, 4'h0};
      wake_q = '{4'h0, 4'h0};
      mdl_st <= 0;
    end else begin
      ack_old = ack_q.pop_front();
      wake_old = wake_q.pop_front();
      ack_q.push_back(ack);
      wake_q.push_back(wsrc);
      case (mdl_st)
        0: if (sleep_ins || (soe && eret && !hp)) mdl_st <= dsel ? 2 : 1;
        1: if (irq) mdl_st <= 0;
        2: if ((wake_old & wen) != 4'h0) mdl_st <= 0;
          else if (ack_old == 4'hf) mdl_st <= 3;
        default: if ((wake_old & wen) != 4'h0) mdl_st <= 0;
      endcase
    end
  end
  task tk;
    @(posedge ref_clk_i);
    #1;
    if (!rst_i) chk({5'h0, st}, mdl_st[7:0]);
  endtask
  task complete_run;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wt(input int s);
    for (n = 0; n < 20 && st !== s[2:0]; n++) tk;
    if (n == 20) begin
      err_total++;
      complete_run;
    end
    chk({st, ce}, {s[2:0], cex(s)});
  endtask
  task go;
    sleep_ins = 1'h1;
    tk;
    sleep_ins = 1'h0;
  endtask
  initial begin
    tk;
    tk;
    rst_i = 1'h0;
    chk({st, ce}, {3'h0, 5'h1f});
    chk({1'h0, sreq, aws, volt_det, freg, hs, fs, irc}, 8'h18);
    for (int m = 0; m < 4; m++) begin
      mode = m[2:0];
      tk;
      chk({3'h0, volt_det, freg, hs, fs, irc},
        {3'h0, m != 2, m != 2, m == 1, m == 2, m == 2});
      go;
      chk({st, ce}, {3'h1, cex(1)});
      chk({7'h0, fs}, {7'h0, m == 2});
      irq = 1'h1;
      tk;
      irq = 1'h0;
      chk({st, ce}, {3'h0, cex(0)});
    end
    {soe, hp, eret} = 3'h7;
    tk;
    eret = 1'h0;
    chk({5'h0, st}, 8'h00);
    {hp, eret} = 2'h1;
    tk;
    eret = 1'h0;
    chk({5'h0, st}, 8'h01);
    {irq, soe, dsel} = 3'h5;
    tk;
    irq = 1'h0;
    for (int m = 0; m < 3; m += 2) begin
      mode = m[2:0];
      slow = m[1];
      tk;
      go;
      chk({st, ce}, {3'h2, cex(2)});
      irq = 1'h1;
      wt(3);
      tk;
      irq = 1'h0;
      lf = lfsr_next(lf);
      wsrc = lf[3:0] | 4'h1;
      wen = ~wsrc;
      repeat (4) tk;
      chk({5'h0, st}, 8'h03);
      wen = 4'hf;
      wt(0);
      chk({7'h0, sreq}, 8'h00);
      wsrc = 4'h0;
    end
    complete_run;
  end
endmodule // pms_power_mode_sequencer_test
